// ===== include/mta_pkg.sv
/*
 * Shared constants, types and the CRC step for the monitor two-wire
 * target with alarm output.
 * Assumes a 10 MHz reference clock and a bus clock that runs only
 * during frames.
 */
package mta_pkg;

   // ==========================================================
   // Timing
   localparam int REF_CLK_KHZ = 10000;
   localparam int TMO_UNIT_US = 100;
   localparam int TMO_UNIT_CYC = (TMO_UNIT_US * REF_CLK_KHZ) / 1000;

   // ==========================================================
   // Register indices on the serial bus
   localparam logic [7:0] REG_STAT = 8'h00;
   localparam logic [7:0] REG_LIVE = 8'h01;
   localparam logic [7:0] REG_MASK = 8'h02;
   localparam logic [7:0] REG_CFG = 8'h03;
   localparam logic [7:0] REG_TADDR = 8'h04;
   localparam logic [7:0] REG_TMO = 8'h05;
   localparam logic [7:0] REG_GEN0 = 8'h06;

   // ==========================================================
   // Field positions and values after reset
   localparam int CFG_CRC_BIT = 0;
   localparam int CFG_UPD_BIT = 1;
   localparam logic [7:0] TADDR_RST = 8'h10;
   localparam logic [7:0] MASK_RST = 8'hff;
   localparam logic [7:0] TMO_RST = 8'h00;
   localparam logic [7:0] CRC_INIT = 8'h00;
   localparam logic [7:0] CRC_POLY = 8'h07;
   localparam logic [3:0] BIT_ACK = 4'h8;

   // ==========================================================
   // Link states, Gray coded along write and read paths
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_ADDR  = 3'b001,
      ST_REG   = 3'b011,
      ST_WDATA = 3'b010,
      ST_WCRC  = 3'b110,
      ST_RDATA = 3'b101,
      ST_RCRC  = 3'b100
   } mta_state_t;

   // Write event carried from link to reference domain
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] data;
   } mta_wr_t;

   // One byte through the CRC, MSB first
   function automatic logic [7:0] mta_crc8(input logic [7:0] crc,
                                          input logic [7:0] din);
      logic [7:0] c;
      c = crc ^ din;
      for (int i = 0; i < 8; i++) begin
         c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
      end
      return c;
   endfunction

endpackage

// ===== logic/mta_target.sv
/*
 * Two-wire bus target with optional CRC, register file and open-drain
 * alarm output of a battery monitor.
 * Assumes: scl_i is the bus clock as a clock port, sda_i the bus data
 * level; the bench resolves the open-drain wires from the enables.
 */
// Function
// - Target only on the two-wire bus, correct up to 400 kHz.
// - Address byte 0x10 write, 0x11 read by default; configurable.
// - CRC mode writable only in update mode; applied on leaving it.
// - Programmable bus timeout resets the serial logic when it expires.
// - Block writes allowed; register address increments after each byte.
// - Device may stretch the clock; controller waits for release.
// - CRC only when enabled; otherwise no CRC bytes on the bus.
// - Running CRC cleared after each check byte and each stop.
// - Single write CRC spans target address, register address, data.
// - Block write: first byte as single; later bytes data only.
// - CRC is eight bits, polynomial x^8+x^2+x+1, starting at zero.
// - Bad write CRC is not acknowledged; bus logic goes idle.
// - Controller NACKs a bad read CRC; device then goes idle.
// - Read with repeated start: CRC runs from first start.
// - Read after stop: CRC covers read address and data only.
// - Block read: controller acks all but last; address increments.
// - Block read, repeated start: first byte from start, then data only.
// - Block read after stop: first byte with read address, then data.
// - Alarm output is open drain, pulled low while an alarm stands.
// - Each flag passes a mask, writable at any time, before alarming.
// - All flags stay latched until the host clears them.
// - Live unlatched copy of every flag is readable.
`timescale 1ns/1ps
module mta_target
   import mta_pkg::*;
#(
   parameter int DEPTH = 16
) (
   // Reference clock and reset
   input wire logic ref_clk_i,
   input wire logic reset_i,
   // Two-wire bus
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe_o,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   // Monitor flags and alarm pin
   input wire logic [7:0] flags_i,
   output logic alert_o,
   output logic alert_oe_o,
   // Status towards the device
   output logic crc_active_o
);

   // ==========================================================
   // Declarations
   mta_state_t state_r;
   logic [3:0] bit_r;
   logic [7:0] shreg_r, tx_r, crc_r, ptr_r;
   logic ack_r, sda_oe_r;
   logic start_tgl_r, stop_tgl_r, start_seen_r, stop_seen_r;
   logic wr_tgl_r, rd_tgl_r;
   mta_wr_t wr_r;
   logic [7:0] rd_addr_r;
   logic [7:0] wdat_r;
   logic crc_s1_r, crc_s2_r;
   logic [7:0] ta_s1_r, ta_s2_r;
   logic [7:0] byte_in;
   logic start_new, stop_new, crc_ok, match, done, wr_go, rd_go;
   logic link_rst;
   // Reference domain
   logic scl_s1_r, scl_s2_r;
   logic wr_s1_r, wr_s2_r, wr_ack_r, rd_s1_r, rd_s2_r, rd_ack_r;
   logic wr_evt, rd_evt;
   logic [7:0] stat_r, mask_r, cfg_r, taddr_r, tmo_r, rd_data_r;
   logic [7:0] flg_s1_r, flg_s2_r;
   logic [7:0] mem_r [DEPTH];
   logic crc_act_r, upd_d_r, tmo_rst_r, alert_oe_r;
   logic [19:0] tmo_cnt_r;

   // Register read decode, shared by the fetch path
   function automatic logic [7:0] reg_read(input logic [7:0] a);
      if (a == REG_STAT) return stat_r;
      else if (a == REG_LIVE) return flg_s2_r;
      else if (a == REG_MASK) return mask_r;
      else if (a == REG_CFG) return cfg_r;
      else if (a == REG_TADDR) return taddr_r;
      else if (a == REG_TMO) return tmo_r;
      else if (a < 8'(DEPTH)) return mem_r[a[$clog2(DEPTH)-1:0]];
      else return 8'h00;
   endfunction

   // ==========================================================
   // Start and stop detection on data edges while clock is high
   always_ff @(negedge sda_i or posedge reset_i) begin
      if (reset_i) start_tgl_r <= 1'b0;
      else if (scl_i) start_tgl_r <= ~start_tgl_r;
   end

   always_ff @(posedge sda_i or posedge reset_i) begin
      if (reset_i) stop_tgl_r <= 1'b0;
      else if (scl_i) stop_tgl_r <= ~stop_tgl_r;
   end

   // ==========================================================
   // Link domain: quasi-static settings, synchronised on each rising bus clock
   always_ff @(posedge scl_i or posedge reset_i) begin
      if (reset_i) begin
         crc_s1_r <= 1'b0;
         crc_s2_r <= 1'b0;
         ta_s1_r <= TADDR_RST;
         ta_s2_r <= TADDR_RST;
      end else begin
         crc_s1_r <= crc_act_r;
         crc_s2_r <= crc_s1_r;
         ta_s1_r <= taddr_r;
         ta_s2_r <= ta_s1_r;
      end
   end

   // Byte and frame decode
   assign link_rst = reset_i | tmo_rst_r;
   assign byte_in = {shreg_r[6:0], sda_i};
   assign start_new = start_tgl_r != start_seen_r;
   assign stop_new = stop_tgl_r != stop_seen_r;
   assign crc_ok = byte_in == crc_r;
   assign match = byte_in[7:1] == ta_s2_r[7:1];
   assign done = !start_new && !stop_new && bit_r == 4'h7;
   assign wr_go = done && ((state_r == ST_WDATA && !crc_s2_r) ||
                           (state_r == ST_WCRC && crc_ok));
   assign rd_go = done && ((state_r == ST_ADDR && match && byte_in[0]) ||
                           (state_r == ST_RDATA && !crc_s2_r) ||
                           state_r == ST_RCRC);

   // Main link state machine, sampling on rising clock
   always_ff @(posedge scl_i or posedge link_rst) begin
      if (link_rst) begin
         state_r <= ST_IDLE;
         bit_r <= 4'h0;
         shreg_r <= 8'h00;
         tx_r <= 8'hff;
         crc_r <= CRC_INIT;
         ptr_r <= 8'h00;
         wdat_r <= 8'h00;
         ack_r <= 1'b0;
      end else if (start_new) begin
         // Repeated start keeps the running CRC, a fresh frame clears it
         state_r <= ST_ADDR;
         shreg_r <= {7'h00, sda_i};
         bit_r <= 4'h1;
         ack_r <= 1'b0;
         if (stop_new || state_r == ST_IDLE) crc_r <= CRC_INIT;
         else crc_r <= crc_r;
      end else if (stop_new || state_r == ST_IDLE) begin
         state_r <= ST_IDLE;
         bit_r <= 4'h0;
         ack_r <= 1'b0;
         crc_r <= CRC_INIT;
      end else if (bit_r != BIT_ACK) begin
         shreg_r <= byte_in;
         bit_r <= bit_r + 4'h1;
         if (bit_r == 4'h7) begin
            case (state_r)
               ST_ADDR: begin
                  ack_r <= match;
                  crc_r <= mta_crc8(crc_r, byte_in);
                  if (!match) state_r <= ST_IDLE;
               end
               ST_REG: begin
                  ack_r <= 1'b1;
                  crc_r <= mta_crc8(crc_r, byte_in);
                  ptr_r <= byte_in;
               end
               ST_WDATA: begin
                  ack_r <= 1'b1;
                  // Kept aside: the shifter is reused for the check byte
                  wdat_r <= byte_in;
                  if (crc_s2_r) crc_r <= mta_crc8(crc_r, byte_in);
                  else crc_r <= CRC_INIT;
                  if (!crc_s2_r) ptr_r <= ptr_r + 8'h01;
               end
               ST_WCRC: begin
                  ack_r <= crc_ok;
                  crc_r <= CRC_INIT;
                  if (crc_ok) ptr_r <= ptr_r + 8'h01;
                  else state_r <= ST_IDLE;
               end
               ST_RDATA: begin
                  ack_r <= 1'b0;
                  if (crc_s2_r) crc_r <= mta_crc8(crc_r, tx_r);
                  else crc_r <= CRC_INIT;
                  if (!crc_s2_r) ptr_r <= ptr_r + 8'h01;
               end
               ST_RCRC: begin
                  ack_r <= 1'b0;
                  crc_r <= CRC_INIT;
                  ptr_r <= ptr_r + 8'h01;
               end
               default: ack_r <= 1'b0;
            endcase
         end
      end else begin
         // Acknowledge slot: pick the next byte's role
         bit_r <= 4'h0;
         ack_r <= 1'b0;
         case (state_r)
            ST_ADDR: begin
               state_r <= shreg_r[0] ? ST_RDATA : ST_REG;
               tx_r <= rd_data_r;
            end
            ST_REG: state_r <= ST_WDATA;
            ST_WDATA: state_r <= crc_s2_r ? ST_WCRC : ST_WDATA;
            ST_WCRC: state_r <= ST_WDATA;
            ST_RDATA: begin
               // Controller NACK ends a block read
               if (sda_i) state_r <= ST_IDLE;
               else if (crc_s2_r) state_r <= ST_RCRC;
               tx_r <= crc_s2_r ? crc_r : rd_data_r;
            end
            ST_RCRC: begin
               if (sda_i) state_r <= ST_IDLE;
               else state_r <= ST_RDATA;
               tx_r <= rd_data_r;
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // Event toggles survive a timeout so the handshakes stay paired
   always_ff @(posedge scl_i or posedge reset_i) begin
      if (reset_i) begin
         start_seen_r <= 1'b0;
         stop_seen_r <= 1'b0;
         wr_tgl_r <= 1'b0;
         rd_tgl_r <= 1'b0;
         wr_r <= '0;
         rd_addr_r <= 8'h00;
      end else begin
         start_seen_r <= start_tgl_r;
         stop_seen_r <= stop_tgl_r;
         if (wr_go) begin
            wr_tgl_r <= ~wr_tgl_r;
            wr_r <= '{addr: ptr_r, data: (state_r == ST_WCRC) ?
                      wdat_r : byte_in};
         end
         if (rd_go) begin
            rd_tgl_r <= ~rd_tgl_r;
            rd_addr_r <= (state_r == ST_ADDR) ? ptr_r : ptr_r + 8'h01;
         end
      end
   end

   // Data drive on falling clock: acknowledge or transmit bit
   always_ff @(negedge scl_i or posedge link_rst) begin
      if (link_rst) sda_oe_r <= 1'b0;
      else sda_oe_r <= (bit_r == BIT_ACK && ack_r) ||
                       ((state_r == ST_RDATA || state_r == ST_RCRC) &&
                        bit_r < BIT_ACK && !tx_r[3'd7 - bit_r[2:0]]);
   end

   assign sda_o = 1'b0;
   assign sda_oe_o = sda_oe_r;

   // ==========================================================
   // Reference domain: synchronisers for bus clock and toggles
   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         scl_s1_r <= 1'b1;
         scl_s2_r <= 1'b1;
         flg_s1_r <= 8'h00;
         flg_s2_r <= 8'h00;
         wr_s1_r <= 1'b0;
         wr_s2_r <= 1'b0;
         wr_ack_r <= 1'b0;
         rd_s1_r <= 1'b0;
         rd_s2_r <= 1'b0;
         rd_ack_r <= 1'b0;
      end else begin
         scl_s1_r <= scl_i;
         scl_s2_r <= scl_s1_r;
         // Monitor flags come from another domain
         flg_s1_r <= flags_i;
         flg_s2_r <= flg_s1_r;
         wr_s1_r <= wr_tgl_r;
         wr_s2_r <= wr_s1_r;
         wr_ack_r <= wr_s2_r;
         rd_s1_r <= rd_tgl_r;
         rd_s2_r <= rd_s1_r;
         rd_ack_r <= rd_s2_r;
      end
   end

   assign wr_evt = wr_s2_r != wr_ack_r;
   assign rd_evt = rd_s2_r != rd_ack_r;
   // Hold the clock low until fetched data is stable; the request
   // needs two reference cycles to arrive, well inside a low phase
   assign scl_o = 1'b0;
   assign scl_oe_o = rd_evt;

   // Host writes into the register file; flags set over the clear
   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         stat_r <= 8'h00;
         mask_r <= MASK_RST;
         cfg_r <= 8'h00;
         taddr_r <= TADDR_RST;
         tmo_r <= TMO_RST;
      end else begin
         if (wr_evt && wr_r.addr == REG_STAT)
            stat_r <= (stat_r & ~wr_r.data) | flg_s2_r;
         else stat_r <= stat_r | flg_s2_r;
         if (wr_evt && wr_r.addr == REG_MASK) mask_r <= wr_r.data;
         if (wr_evt && wr_r.addr == REG_CFG) begin
            cfg_r[CFG_UPD_BIT] <= wr_r.data[CFG_UPD_BIT];
            if (cfg_r[CFG_UPD_BIT])
               cfg_r[CFG_CRC_BIT] <= wr_r.data[CFG_CRC_BIT];
         end
         if (wr_evt && wr_r.addr == REG_TADDR) taddr_r <= wr_r.data;
         if (wr_evt && wr_r.addr == REG_TMO) tmo_r <= wr_r.data;
      end
   end

   // General storage above the named registers
   always_ff @(posedge ref_clk_i) begin
      if (wr_evt && wr_r.addr >= REG_GEN0 && wr_r.addr < 8'(DEPTH))
         mem_r[wr_r.addr[$clog2(DEPTH)-1:0]] <= wr_r.data;
   end

   // Fetch answers a read request; live flags read unlatched
   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) rd_data_r <= 8'h00;
      else if (rd_evt) rd_data_r <= reg_read(rd_addr_r);
   end

   // CRC mode takes effect only when update mode is left
   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         upd_d_r <= 1'b0;
         crc_act_r <= 1'b0;
      end else begin
         upd_d_r <= cfg_r[CFG_UPD_BIT];
         if (upd_d_r && !cfg_r[CFG_UPD_BIT])
            crc_act_r <= cfg_r[CFG_CRC_BIT];
      end
   end

   assign crc_active_o = crc_act_r;

   // Timeout: clock held low by the controller too long. Our own
   // stretch is excluded, so a slow fetch never trips it.
   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         tmo_cnt_r <= 20'h00000;
         tmo_rst_r <= 1'b0;
      end else if (tmo_r == 8'h00 || scl_s2_r || rd_evt || tmo_rst_r) begin
         tmo_cnt_r <= 20'h00000;
         tmo_rst_r <= 1'b0;
      end else begin
         tmo_cnt_r <= tmo_cnt_r + 20'h00001;
         tmo_rst_r <= tmo_cnt_r ==
                      20'(int'(tmo_r) * TMO_UNIT_CYC - 1);
      end
   end

   // Alarm: masked latched flags pull the open-drain pin low
   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) alert_oe_r <= 1'b0;
      else alert_oe_r <= |(stat_r & mask_r);
   end

   assign alert_o = 1'b0;
   assign alert_oe_o = alert_oe_r;

   // ==========================================================
   // Assertions
   AST_STAT_SET: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      ((stat_r & $past(flg_s2_r)) == $past(flg_s2_r)))
      else $error("flag did not latch");
   AST_STAT_HOLD: assert property (@(posedge ref_clk_i)
      disable iff (reset_i)
      !wr_evt |=> ((stat_r & $past(stat_r)) == $past(stat_r)))
      else $error("latched flag lost without host clear");
   AST_ALERT_ON: assert property (@(posedge ref_clk_i)
      disable iff (reset_i)
      |(flg_s2_r & mask_r) ##1 $stable(mask_r) |=> alert_oe_o)
      else $error("alarm not raised");
   AST_MASK_GATE: assert property (@(posedge ref_clk_i)
      disable iff (reset_i)
      (mask_r == 8'h00) |=> !alert_oe_o)
      else $error("masked flag raised alarm");
   AST_CRC_LOCK: assert property (@(posedge ref_clk_i)
      disable iff (reset_i)
      !cfg_r[CFG_UPD_BIT] |=> $stable(cfg_r[CFG_CRC_BIT]))
      else $error("crc mode changed outside update mode");
   AST_CRC_APPLY: assert property (@(posedge ref_clk_i)
      disable iff (reset_i)
      $changed(crc_act_r) |-> $past(upd_d_r) && !$past(cfg_r[CFG_UPD_BIT]))
      else $error("crc mode applied while still updating");
   AST_TMO_OFF: assert property (@(posedge ref_clk_i)
      disable iff (reset_i)
      (tmo_r == 8'h00) |=> !tmo_rst_r)
      else $error("timeout fired while disabled");
   AST_TMO_PULSE: assert property (@(posedge ref_clk_i)
      disable iff (reset_i)
      tmo_rst_r |=> !tmo_rst_r && tmo_cnt_r == 20'h00000)
      else $error("timeout reset not a single pulse");
   AST_LIVE_READ: assert property (@(posedge ref_clk_i)
      disable iff (reset_i)
      rd_evt && rd_addr_r == REG_LIVE |=> rd_data_r == $past(flg_s2_r))
      else $error("live flags not returned");
   AST_WCRC_NACK: assert property (@(posedge scl_i) disable iff (link_rst)
      done && state_r == ST_WCRC && !crc_ok |=> !ack_r && state_r == ST_IDLE)
      else $error("bad write crc acknowledged");
   AST_WR_INC: assert property (@(posedge scl_i) disable iff (link_rst)
      wr_go |=> ptr_r == $past(ptr_r) + 8'h01)
      else $error("register address did not advance");

   COV_WRITE: cover property (@(posedge ref_clk_i) disable iff (reset_i)
      wr_evt);
   COV_READ: cover property (@(posedge ref_clk_i) disable iff (reset_i)
      rd_evt ##1 !scl_oe_o);
   COV_CRC_FAIL: cover property (@(posedge scl_i) disable iff (link_rst)
      done && state_r == ST_WCRC && !crc_ok);
   COV_TMO: cover property (@(posedge ref_clk_i) disable iff (reset_i)
      tmo_rst_r);

endmodule // mta_target

// ===== tb/mta_host.sv
/*
 * Bus controller model that drives the two-wire target from the far side.
 * Assumes the bench resolves both wires with pull-ups from all pulls.
 */
`timescale 1ns/1ps
module mta_host (
   // Resolved bus levels
   input wire logic scl_i,
   input wire logic sda_i,
   // Open-drain pulls, high means pulled low
   output logic scl_low_o,
   output logic sda_low_o
);
   // ==========================================================
   // Bus idles released, clock stands still between frames
   initial begin
      scl_low_o = 1'b0;
      sda_low_o = 1'b0;
   end

   // One byte through the running check value, MSB first
   function automatic logic [7:0] crc8(input logic [7:0] c,
                                       input logic [7:0] d);
      logic [7:0] x;
      x = c ^ d;
      for (int i = 0; i < 8; i++) begin
         x = x[7] ? ((x << 1) ^ 8'h07) : (x << 1);
      end
      return x;
   endfunction

   // One bit; long low phase so a stretch lands before the rise
   task automatic bit_x(input logic b, output logic r);
      int n;
      sda_low_o = ~b;
      #300;
      scl_low_o = 1'b0;
      n = 0;
      while (scl_i !== 1'b1 && n < 100) begin
         #10;
         n++;
      end
      r = sda_i;
      #80;
      scl_low_o = 1'b1;
      #300;
   endtask

   // Start or repeated start, from either idle or a low clock
   task automatic start();
      sda_low_o = 1'b0;
      #150;
      scl_low_o = 1'b0;
      #150;
      sda_low_o = 1'b1;
      #150;
      scl_low_o = 1'b1;
   endtask

   // Stop, which also clears the running check value
   task automatic stop();
      sda_low_o = 1'b1;
      #150;
      scl_low_o = 1'b0;
      #150;
      sda_low_o = 1'b0;
      #300;
   endtask

   task automatic wbyte(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_x(b[i], r);
      end
      bit_x(1'b1, r);
      ack = (r === 1'b0);
   endtask

   // Ack all but the last byte, then release for the NACK
   task automatic rbyte(input logic ack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_x(1'b1, d[i]);
      end
      bit_x(~ack, r);
   endtask
endmodule // mta_host

// ===== tb/mta_target_test.sv
/*
 * Self-checking bench for the two-wire target with alarm output.
 * Assumes the package constants for register indices and reset values.
 */
`timescale 1ns/1ps
module mta_target_test;
   import mta_pkg::*;
   logic ref_clk, reset, scl_oe, sda_oe, alert_oe, crc_act;
   logic scl_low, sda_low, scl, sda;
   logic [7:0] flags, ta;
   logic [15:0] d;
   logic a;
   bit crc_on;
   int fails, checked, cyc;

   // ==========================================================
   // Clock and wires with pull-ups
   initial ref_clk = 1'b0;
   always #50 ref_clk = ~ref_clk;
   assign scl = ~(scl_low | scl_oe);
   assign sda = ~(sda_low | sda_oe);

   mta_target #(.DEPTH(16)) DUT (.ref_clk_i(ref_clk), .reset_i(reset),
      .scl_i(scl), .scl_o(), .scl_oe_o(scl_oe), .sda_i(sda), .sda_o(),
      .sda_oe_o(sda_oe), .flags_i(flags), .alert_o(),
      .alert_oe_o(alert_oe), .crc_active_o(crc_act));
   mta_host H (.scl_i(scl), .sda_i(sda), .scl_low_o(scl_low),
      .sda_low_o(sda_low));

   task automatic give_verdict();
      $display("Checks %0d, mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, exp, input string what);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   // Write n bytes; bad flips the low bit of every check byte
   task automatic wr(input logic [7:0] r, d0, input logic [7:0] d1 = 8'h00,
                     input int n = 1, input bit bad = 0,
                     input logic ea = 1'b1);
      logic [7:0] c;
      H.start();
      H.wbyte(ta, a);
      chk(16'(a), 16'(ea), "address ack");
      if (a) begin
         H.wbyte(r, a);
         c = H.crc8(H.crc8(8'h00, ta), r);
         for (int i = 0; i < n; i++) begin
            H.wbyte(i ? d1 : d0, a);
            chk(16'(a), 16'h1, "data ack");
            if (crc_on) begin
               c = H.crc8(i ? 8'h00 : c, i ? d1 : d0);
               H.wbyte(c ^ {7'h0, bad}, a);
               chk(16'(a), 16'(!bad), "check byte ack");
            end
         end
      end
      H.stop();
      repeat (4) @(posedge ref_clk);
   endtask

   // Read n bytes, with repeated start or with a stop in between
   task automatic rd(input logic [7:0] r, input int n, input bit sr);
      logic [7:0] c, b, cr;
      d = 16'h0;
      H.start();
      H.wbyte(ta, a);
      H.wbyte(r, a);
      c = H.crc8(H.crc8(8'h00, ta), r);
      if (!sr) begin
         H.stop();
         c = 8'h00;
      end
      H.start();
      H.wbyte(ta | 8'h01, a);
      chk(16'(a), 16'h1, "read address ack");
      c = H.crc8(c, ta | 8'h01);
      for (int i = 0; i < n; i++) begin
         H.rbyte(crc_on || i < n - 1, b);
         d = {d[7:0], b};
         if (crc_on) begin
            c = H.crc8(i ? 8'h00 : c, b);
            H.rbyte(i < n - 1, cr);
            chk(16'(cr), 16'(c), "read check byte");
         end
      end
      H.stop();
      repeat (4) @(posedge ref_clk);
   endtask

   // Hang guard; the longest run is well under this
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 30000) begin
         fails++;
         $display("[FAIL] %0t run did not finish", $time);
         give_verdict();
      end
   end

   // ==========================================================
   // Main sequence
   initial begin
      reset = 1'b1;
      flags = 8'h00;
      ta = 8'h10;
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk) reset = 1'b0;
      repeat (4) @(posedge ref_clk);
      chk(16'(crc_act), 16'h0, "check mode after reset");
      rd(REG_TADDR, 2, 1);
      chk(d, {TADDR_RST, TMO_RST}, "address and timeout");
      wr(REG_GEN0, 8'ha5, 8'h3c, 2);
      rd(REG_GEN0, 2, 1);
      chk(d, 16'ha53c, "block read");
      wr(REG_TADDR, 8'h5a);
      ta = 8'h10;
      wr(REG_GEN0, 8'h00, 8'h00, 1, 0, 1'b0);
      ta = 8'h5a;
      wr(REG_TADDR, 8'h10);
      ta = 8'h10;
      // Alarm path: latch, live copy, mask, clear
      @(negedge ref_clk) flags = 8'h24;
      repeat (4) @(posedge ref_clk);
      @(negedge ref_clk);
      chk(16'(alert_oe), 16'h1, "alarm raised");
      rd(REG_STAT, 2, 1);
      chk(d, 16'h2424, "latched and live");
      @(negedge ref_clk) flags = 8'h00;
      rd(REG_STAT, 2, 0);
      chk(d, 16'h2400, "latch holds");
      wr(REG_MASK, 8'hdb);
      chk(16'(alert_oe), 16'h0, "alarm masked");
      wr(REG_MASK, 8'h04);
      chk(16'(alert_oe), 16'h1, "alarm unmasked");
      wr(REG_STAT, 8'h04);
      chk(16'(alert_oe), 16'h0, "alarm cleared");
      rd(REG_STAT, 1, 1);
      chk(d, 16'h0020, "other flag kept");
      wr(REG_MASK, 8'hff);
      // Check mode only changes through the update mode
      wr(REG_CFG, 8'h01);
      chk(16'(crc_act), 16'h0, "mode outside update");
      wr(REG_CFG, 8'h02);
      wr(REG_CFG, 8'h03);
      chk(16'(crc_act), 16'h0, "mode before exit");
      wr(REG_CFG, 8'h01);
      chk(16'(crc_act), 16'h1, "mode on exit");
      crc_on = 1'b1;
      wr(REG_GEN0, 8'h11, 8'h22, 2);
      wr(REG_GEN0 + 8'h02, 8'h99, 8'h00, 1, 1);
      rd(REG_GEN0, 2, 1);
      chk(d, 16'h1122, "checked block read");
      rd(REG_GEN0, 1, 0);
      chk(d, 16'h0011, "checked read after stop");
      wr(REG_CFG, 8'h03);
      wr(REG_CFG, 8'h02);
      wr(REG_CFG, 8'h00);
      chk(16'(crc_act), 16'h0, "mode off");
      crc_on = 1'b0;
      // Timeout drops a frame whose clock is held low too long
      wr(REG_TMO, 8'h01);
      H.start();
      H.wbyte(ta, a);
      #120000;
      H.wbyte(REG_GEN0, a);
      chk(16'(a), 16'h0, "frame dropped");
      H.stop();
      wr(REG_TMO, 8'h00);
      give_verdict();
   end
endmodule // mta_target_test
